// ===== sac_sequencer.sv
// Notes on behaviour
// - sample serial input on each serial clock rise of the word into the address register.
// - leading zeros are ignored; the first high bit is the start bit.
// - the next two to four bits after the start bit form the assignment word.
// - once the word is in, fix the channel, then wait half a clock to settle.
// - raise conversion_active at settling start and stop accepting serial input.
// - leave high impedance and drive zero during the settling period.
// - each comparator decision appears on a falling edge, most significant first.
// - conversion ends after eight periods; status drops half a clock later.
// - keep the result; without shift enable, resend it least significant first.
// - after the result, drive the output low until chip select goes high.
// - with shift enable high hold the lsb; when low, shift lsb first.
// - the single-input variant sends only the most-significant-first stream.
// - chip select high clears every register and the sequencer.
// - serial input is read only while addressing, output still undriven.
// - word is single/diff bit, odd/sign bit, then up to two select bits.
// - the single-input variant needs no word; conversion follows the start bit.
module sac_sequencer #(
  parameter int WORD_BITS = sac_pkg::SAC_WORD_BITS_DEF,
  parameter bit HAS_SE    = sac_pkg::SAC_HAS_SE_DEF
) (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              serial_clk,
  input  wire logic              chip_select_n,
  input  wire logic              serial_in,
  input  wire logic              lsb_shift_enable_n,
  input  wire logic              comp_above,
  output logic                   data_out,
  output logic                   data_out_en,
  output logic                   conversion_active,
  output sac_pkg::sac_chan_t     channel,
  output logic [7:0]             ladder_code
);

  // ==========================================================================
  // pin synchronisers
  // ==========================================================================
  logic sck_rise;
  logic sck_fall;
  logic cs_n_s;
  logic din_s;
  logic se_n_s;
  logic comp_s;

  sac_pin_sync #(.INIT(1'b0)) u_sck (.clk(clk), .resetn(resetn), .pin(serial_clk),
    .level(), .rise(sck_rise), .fall(sck_fall));
  sac_pin_sync #(.INIT(1'b1)) u_cs (.clk(clk), .resetn(resetn), .pin(chip_select_n),
    .level(cs_n_s), .rise(), .fall());
  sac_pin_sync #(.INIT(1'b0)) u_din (.clk(clk), .resetn(resetn), .pin(serial_in),
    .level(din_s), .rise(), .fall());
  sac_pin_sync #(.INIT(1'b1)) u_se (.clk(clk), .resetn(resetn), .pin(lsb_shift_enable_n),
    .level(se_n_s), .rise(), .fall());
  sac_pin_sync #(.INIT(1'b0)) u_cmp (.clk(clk), .resetn(resetn), .pin(comp_above),
    .level(comp_s), .rise(), .fall());

  // ==========================================================================
  // word decode
  // ==========================================================================
  localparam bit ONLY_MSB = (WORD_BITS == 0);

  function automatic sac_pkg::sac_chan_t decode_word(input logic [3:0] w);
    logic [3:0]         a;
    sac_pkg::sac_chan_t c;
    a = 4'(w << (4 - WORD_BITS));
    c.single_vs_differential = a[3];
    c.odd_sign = a[2];
    c.select = (WORD_BITS == 4) ? w[1:0] : ((WORD_BITS == 3) ? {1'b0, w[0]} : 2'h0);
    return c;
  endfunction

  sac_pkg::sac_state_t state;
  logic [2:0]          cnt;
  logic [3:0]          addr;
  logic [7:0]          mask;
  logic                go_settle;
  logic                tail_step;

  assign go_settle = !cs_n_s && sck_rise &&
                     ((state == sac_pkg::SAC_IDLE && din_s && ONLY_MSB) ||
                      (state == sac_pkg::SAC_ADDR && cnt == 3'h1));
  // without shift enable the lsb-first stream runs on its own
  assign tail_step = sck_fall && (!HAS_SE || !se_n_s);

  // ==========================================================================
  // sequencer
  // ==========================================================================
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= sac_pkg::SAC_IDLE;
      cnt   <= sac_pkg::SAC_CNT_RESET;
    end else if (cs_n_s) begin
      state <= sac_pkg::SAC_IDLE;
      cnt   <= sac_pkg::SAC_CNT_RESET;
    end else begin
      case (state)
        sac_pkg::SAC_IDLE: begin
          if (sck_rise && din_s) begin
            state <= ONLY_MSB ? sac_pkg::SAC_SETTLE : sac_pkg::SAC_ADDR;
            cnt   <= 3'(WORD_BITS);
          end
        end
        sac_pkg::SAC_ADDR: begin
          if (sck_rise) begin
            cnt <= cnt - 3'h1;
            if (cnt == 3'h1) begin
              state <= sac_pkg::SAC_SETTLE;
            end
          end
        end
        sac_pkg::SAC_SETTLE: begin
          if (sck_fall) begin
            state <= sac_pkg::SAC_CONV;
            cnt   <= sac_pkg::SAC_CNT_RESET;
          end
        end
        sac_pkg::SAC_CONV: begin
          if (sck_fall) begin
            cnt <= cnt + 3'h1;
            if (cnt == sac_pkg::SAC_LAST_CONV_CNT) begin
              state <= sac_pkg::SAC_TAIL;
              cnt   <= sac_pkg::SAC_CNT_RESET;
            end
          end
        end
        sac_pkg::SAC_TAIL: begin
          if (ONLY_MSB && sck_fall) begin
            state <= sac_pkg::SAC_DONE;
          end else if (tail_step) begin
            cnt <= cnt + 3'h1;
            if (cnt == sac_pkg::SAC_LAST_TAIL_CNT) begin
              state <= sac_pkg::SAC_DONE;
            end
          end
        end
        sac_pkg::SAC_DONE: begin
          state <= sac_pkg::SAC_DONE;
        end
        default: begin
          state <= sac_pkg::SAC_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // address register and channel selection
  // ==========================================================================
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      addr    <= sac_pkg::SAC_ADDR_RESET;
      channel <= sac_pkg::SAC_CHAN_RESET;
    end else if (cs_n_s) begin
      addr    <= sac_pkg::SAC_ADDR_RESET;
      channel <= sac_pkg::SAC_CHAN_RESET;
    end else if (sck_rise && state == sac_pkg::SAC_ADDR) begin
      // input is looked at only while the output is still floating
      addr <= {addr[2:0], din_s};
      if (cnt == 3'h1) begin
        channel <= decode_word({addr[2:0], din_s});
      end
    end
  end

  // ==========================================================================
  // successive approximation register
  // ==========================================================================
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ladder_code <= sac_pkg::SAC_CODE_RESET;
      mask        <= sac_pkg::SAC_CODE_RESET;
    end else if (cs_n_s) begin
      ladder_code <= sac_pkg::SAC_CODE_RESET;
      mask        <= sac_pkg::SAC_CODE_RESET;
    end else if (sck_fall && state == sac_pkg::SAC_SETTLE) begin
      ladder_code <= sac_pkg::SAC_FIRST_TRIAL;
      mask        <= sac_pkg::SAC_FIRST_TRIAL;
    end else if (sck_fall && state == sac_pkg::SAC_CONV) begin
      // keep or drop the trial bit, then try the next lower one
      ladder_code <= (ladder_code & ~mask) | (comp_s ? mask : 8'h00) | (mask >> 1);
      mask        <= mask >> 1;
    end
  end

  // ==========================================================================
  // serial output and status
  // ==========================================================================
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      data_out    <= 1'b0;
      data_out_en <= 1'b0;
    end else if (cs_n_s) begin
      data_out    <= 1'b0;
      data_out_en <= 1'b0;
    end else if (go_settle) begin
      data_out    <= 1'b0;
      data_out_en <= 1'b1;
    end else if (sck_fall && state == sac_pkg::SAC_CONV) begin
      data_out <= comp_s;
    end else if (state == sac_pkg::SAC_TAIL && !ONLY_MSB && tail_step) begin
      data_out <= ladder_code[3'(cnt + 3'h1)];
    end else if (sck_fall && (state == sac_pkg::SAC_DONE ||
                              (state == sac_pkg::SAC_TAIL && ONLY_MSB))) begin
      data_out <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      conversion_active <= 1'b0;
    end else if (cs_n_s) begin
      conversion_active <= 1'b0;
    end else if (go_settle) begin
      conversion_active <= 1'b1;
    end else if (sck_rise && (state == sac_pkg::SAC_TAIL || state == sac_pkg::SAC_DONE)) begin
      conversion_active <= 1'b0;
    end
  end

  // ==========================================================================
  // checks
  // ==========================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  cs_clears_a: assert property (cs_n_s |=> !data_out_en && !conversion_active &&
                                state == sac_pkg::SAC_IDLE) else $error("deselect did not clear");
  zero_ignored_a: assert property (state == sac_pkg::SAC_IDLE && sck_rise && !cs_n_s &&
                                   !din_s |=> state == sac_pkg::SAC_IDLE)
    else $error("zero taken as start");
  settle_zero_a: assert property (go_settle |=> conversion_active && data_out_en &&
                                  !data_out) else $error("settle output wrong");
  input_closed_a: assert property (conversion_active |-> state != sac_pkg::SAC_IDLE &&
                                   state != sac_pkg::SAC_ADDR) else $error("input still open");
  decision_out_a: assert property (state == sac_pkg::SAC_CONV && sck_fall && !cs_n_s
                                   |=> data_out == $past(comp_s))
    else $error("decision not shown");
  first_trial_a: assert property (state == sac_pkg::SAC_SETTLE && sck_fall && !cs_n_s
                                  |=> ladder_code == 8'h80) else $error("first trial not msb");
  status_drop_a: assert property (state == sac_pkg::SAC_TAIL && sck_rise && !cs_n_s
                                  |=> !conversion_active) else $error("status not lowered");
  done_low_a: assert property (state == sac_pkg::SAC_DONE && sck_fall && !cs_n_s
                               |=> !data_out && data_out_en) else $error("output not low at end");
  lsb_hold_a: assert property (HAS_SE && state == sac_pkg::SAC_TAIL && se_n_s && !cs_n_s
                               |=> $stable(data_out)) else $error("lsb not held");
  settle_end_a: assert property (state == sac_pkg::SAC_SETTLE && sck_fall && !cs_n_s
                                 |=> state == sac_pkg::SAC_CONV)
    else $error("conversion not begun");
  // mask and cnt run apart, so this ties the length to the eighth decision
  conv_length_a: assert property (state == sac_pkg::SAC_CONV && sck_fall && !cs_n_s &&
                                  mask == 8'h01 |=> state == sac_pkg::SAC_TAIL)
    else $error("conversion not eight periods");

  conv_start_c: cover property (go_settle);
  lsb_stream_c: cover property (state == sac_pkg::SAC_TAIL && tail_step);
  sequence_done_c: cover property (state == sac_pkg::SAC_DONE && sck_fall);
  abort_c: cover property (state == sac_pkg::SAC_CONV ##1 cs_n_s);

endmodule // sac_sequencer

// ===== sac_pkg.sv
package sac_pkg;

  // ==========================================================================
  // sequencer states, gray coded along the normal path
  // ==========================================================================
  typedef enum logic [2:0] {
    SAC_IDLE   = 3'b000,
    SAC_ADDR   = 3'b001,
    SAC_SETTLE = 3'b011,
    SAC_CONV   = 3'b010,
    SAC_TAIL   = 3'b110,
    SAC_DONE   = 3'b111
  } sac_state_t;

  // ==========================================================================
  // channel assignment carried to the multiplexer
  // ==========================================================================
  typedef struct packed {
    logic       single_vs_differential;
    logic       odd_sign;
    logic [1:0] select;
  } sac_chan_t;

  localparam sac_chan_t  SAC_CHAN_RESET     = '{single_vs_differential: 1'b0,
                                                odd_sign: 1'b0, select: 2'h0};
  localparam int         SAC_WORD_BITS_DEF  = 4;
  localparam bit         SAC_HAS_SE_DEF     = 1'b1;
  localparam int         SAC_RESULT_BITS    = 8;
  localparam logic [7:0] SAC_FIRST_TRIAL    = 8'h80;
  localparam logic [7:0] SAC_CODE_RESET     = 8'h00;
  localparam logic [3:0] SAC_ADDR_RESET     = 4'h0;
  localparam logic [2:0] SAC_CNT_RESET      = 3'h0;
  localparam logic [2:0] SAC_LAST_CONV_CNT  = 3'h7;
  localparam logic [2:0] SAC_LAST_TAIL_CNT  = 3'h6;
  localparam logic [2:0] SAC_SYNC_RESET     = 3'h0;

endpackage

// ===== sac_pin_sync.sv
// ============================================================================
// two-stage synchroniser with edge pulses on the settled level
// ============================================================================
module sac_pin_sync #(
  parameter logic INIT = 1'b0
) (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic pin,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  logic meta;
  logic stable;
  logic last;

  // meta feeds only the second stage; edges look at stable and last
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta   <= INIT;
      stable <= INIT;
      last   <= INIT;
    end else begin
      meta   <= pin;
      stable <= meta;
      last   <= stable;
    end
  end

  assign level = stable;
  assign rise  = stable & ~last;
  assign fall  = ~stable & last;

endmodule // sac_pin_sync

// ===== sac_host_model.sv
// ============================================================================
// host side: drives select, serial clock, data in and shift enable
// ============================================================================
module sac_host_model (
  input  wire logic clk,
  output logic      serial_clk,
  output logic      chip_select_n,
  output logic      serial_in,
  output logic      lsb_shift_enable_n,
  input  wire logic data_out,
  input  wire logic data_out_en
);
  timeunit 1ns;
  timeprecision 100ps;

  // half a serial period in system clocks, well above the sync latency
  localparam int HALF = 8;

  initial begin
    serial_clk         = 1'b0;
    chip_select_n      = 1'b1;
    serial_in          = 1'b0;
    lsb_shift_enable_n = 1'b1;
  end

  task automatic wait_half();
    repeat (HALF) @(posedge clk);
    #2;
  endtask

  task automatic select();
    serial_clk    = 1'b0;
    chip_select_n = 1'b0;
    wait_half();
  endtask

  // serial clock stands low between frames
  task automatic deselect();
    serial_clk         = 1'b0;
    chip_select_n      = 1'b1;
    lsb_shift_enable_n = 1'b1;
    wait_half();
  endtask

  task automatic set_shift(input logic en_n);
    lsb_shift_enable_n = en_n;
  endtask

  // one serial period: data set at the fall, output read just before the rise
  task automatic pulse(input logic din, output logic dout);
    serial_clk = 1'b0;
    serial_in  = din;
    wait_half();
    // a released line reads inverted, so a float is never mistaken for data
    dout       = data_out_en ? data_out : !data_out;
    serial_clk = 1'b1;
    wait_half();
  endtask
endmodule // sac_host_model

// ===== serial_adc_conversion_sequencer_test.sv
// ============================================================================
// bench for the conversion sequencer, full variant plus two smaller ones
// ============================================================================
module serial_adc_conversion_sequencer_test;
  timeunit 1ns;
  timeprecision 100ps;

  logic               clk;
  logic               resetn;
  logic               serial_clk;
  logic               chip_select_n;
  logic               serial_in;
  logic               lsb_shift_enable_n;
  logic               comp_above;
  logic               data_out;
  logic               data_out_en;
  logic               conversion_active;
  sac_pkg::sac_chan_t channel;
  logic [7:0]         ladder_code;
  logic               comp_above_auto;
  logic               data_out_auto;
  logic               data_out_en_auto;
  logic               conversion_active_auto;
  sac_pkg::sac_chan_t channel_auto;
  logic [7:0]         ladder_code_auto;
  logic               comp_above_msb;
  logic               data_out_msb;
  logic               data_out_en_msb;
  logic               conversion_active_msb;
  sac_pkg::sac_chan_t channel_msb;
  logic [7:0]         ladder_code_msb;
  logic [7:0]         vin;
  int                 n_errors;
  int                 n_checks;

  // ideal comparator: analog input sits half a step above vin
  assign comp_above = (vin >= ladder_code);
  assign comp_above_auto = (vin >= ladder_code_auto);
  assign comp_above_msb  = (vin >= ladder_code_msb);

  sac_sequencer sac_sequencer_i (
    .clk                (clk),
    .resetn             (resetn),
    .serial_clk         (serial_clk),
    .chip_select_n      (chip_select_n),
    .serial_in          (serial_in),
    .lsb_shift_enable_n (lsb_shift_enable_n),
    .comp_above         (comp_above),
    .data_out           (data_out),
    .data_out_en        (data_out_en),
    .conversion_active  (conversion_active),
    .channel            (channel),
    .ladder_code        (ladder_code)
  );

  sac_host_model sac_host_model_i (
    .clk                (clk),
    .serial_clk         (serial_clk),
    .chip_select_n      (chip_select_n),
    .serial_in          (serial_in),
    .lsb_shift_enable_n (lsb_shift_enable_n),
    .data_out           (data_out),
    .data_out_en        (data_out_en)
  );

  // smaller variants share the host pins: two-bit word without shift enable, and no word
  sac_sequencer #(.WORD_BITS(2), .HAS_SE(1'b0)) sac_sequencer_auto_i (
    .clk                (clk),
    .resetn             (resetn),
    .serial_clk         (serial_clk),
    .chip_select_n      (chip_select_n),
    .serial_in          (serial_in),
    .lsb_shift_enable_n (lsb_shift_enable_n),
    .comp_above         (comp_above_auto),
    .data_out           (data_out_auto),
    .data_out_en        (data_out_en_auto),
    .conversion_active  (conversion_active_auto),
    .channel            (channel_auto),
    .ladder_code        (ladder_code_auto)
  );

  sac_sequencer #(.WORD_BITS(0), .HAS_SE(1'b0)) sac_sequencer_msb_i (
    .clk                (clk),
    .resetn             (resetn),
    .serial_clk         (serial_clk),
    .chip_select_n      (chip_select_n),
    .serial_in          (serial_in),
    .lsb_shift_enable_n (lsb_shift_enable_n),
    .comp_above         (comp_above_msb),
    .data_out           (data_out_msb),
    .data_out_en        (data_out_en_msb),
    .conversion_active  (conversion_active_msb),
    .channel            (channel_msb),
    .ladder_code        (ladder_code_msb)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ==========================================================================
  // compare and closing tasks
  // ==========================================================================
  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk_cleared();
    chk_bit(data_out_en, 1'b0);
    chk_bit(conversion_active, 1'b0);
    chk_byte({4'h0, channel}, 8'h00);
    chk_byte(ladder_code, 8'h00);
  endtask

  // ==========================================================================
  // one full frame: leading zeros, start, word, result both ways, tail
  // ==========================================================================
  task automatic run_conv(input logic [3:0] word, input logic [7:0] code, input int hold);
    logic       d;
    logic [7:0] msb;
    vin = code;
    sac_host_model_i.select();
    sac_host_model_i.pulse(1'b0, d);
    sac_host_model_i.pulse(1'b0, d);
    sac_host_model_i.pulse(1'b1, d);
    chk_bit(data_out_en, 1'b0);
    for (int i = 3; i >= 0; i--) begin
      sac_host_model_i.pulse(word[i], d);
      chk_bit(conversion_active, i == 0);
      chk_bit(data_out_en, i == 0);
    end
    chk_byte({4'h0, channel}, {4'h0, word});
    // a high level here must not be taken as a new start bit
    sac_host_model_i.pulse(1'b1, d);
    chk_bit(d, 1'b0);
    for (int i = 7; i >= 0; i--) begin
      sac_host_model_i.pulse(i[0], d);
      msb[i] = d;
      chk_bit(conversion_active, i != 0);
    end
    chk_byte(msb, code);
    for (int k = 0; k < hold; k++) begin
      sac_host_model_i.pulse(k[0], d);
      chk_bit(d, code[0]);
    end
    sac_host_model_i.set_shift(1'b0);
    for (int i = 1; i < 8; i++) begin
      sac_host_model_i.pulse(i[0], d);
      chk_bit(d, code[i]);
    end
    for (int k = 0; k < 3; k++) begin
      sac_host_model_i.pulse(1'b1, d);
      chk_bit(d, 1'b0);
    end
    chk_bit(data_out_en, 1'b1);
    chk_byte({4'h0, channel}, {4'h0, word});
    sac_host_model_i.deselect();
    chk_cleared();
  endtask

  // ==========================================================================
  // variant frames: start bit, two word bits, then twenty periods in all
  // ==========================================================================
  // expected serial bit n periods after the settling rise
  function automatic logic exp_out(input int n, input logic [7:0] code, input bit lsb_too);
    if (n >= 2 && n <= 9)
      return code[9 - n];
    if (lsb_too && n >= 10 && n <= 16)
      return code[n - 9];
    return 1'b0;
  endfunction

  task automatic run_var(input logic [1:0] word, input logic [7:0] code);
    logic d;
    vin = code;
    sac_host_model_i.select();
    for (int p = 1; p <= 20; p++) begin
      sac_host_model_i.pulse(p == 1 || (p <= 3 && word[3 - p]), d);
      chk_bit(data_out_auto, exp_out(p - 3, code, 1'b1));
      chk_bit(data_out_msb, exp_out(p - 1, code, 1'b0));
      chk_bit(data_out_en_auto, p >= 3);
      chk_bit(data_out_en_msb, 1'b1);
      chk_bit(conversion_active_auto, p >= 3 && p < 12);
      chk_bit(conversion_active_msb, p < 10);
    end
    chk_byte({4'h0, channel_auto}, {4'h0, word, 2'h0});
    chk_byte({4'h0, channel_msb}, 8'h00);
    chk_byte(ladder_code_auto, code);
    chk_byte(ladder_code_msb, code);
    sac_host_model_i.deselect();
  endtask

  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial begin : main
    logic d;
    n_errors = 0;
    n_checks = 0;
    vin      = 8'h00;
    resetn   = 1'b0;
    repeat (5) @(posedge clk);
    #2;
    resetn = 1'b1;
    repeat (4) @(posedge clk);
    #2;
    chk_cleared();
    run_conv(4'hF, 8'hA5, 2);
    run_conv(4'h8, 8'h00, 0);
    run_conv(4'h5, 8'hFF, 3);
    run_conv(4'h2, 8'h3C, 1);
    run_var(2'h2, 8'hC3);
    run_var(2'h1, 8'h3A);
    // abort in mid conversion, then a clean frame must still work
    vin = 8'h5A;
    sac_host_model_i.select();
    sac_host_model_i.pulse(1'b1, d);
    for (int i = 0; i < 7; i++)
      sac_host_model_i.pulse(i[0], d);
    chk_bit(conversion_active, 1'b1);
    sac_host_model_i.deselect();
    chk_cleared();
    run_conv(4'hB, 8'h81, 1);
    wrap_up();
  end

  initial begin : watchdog
    repeat (20000) @(posedge clk);
    n_errors++;
    wrap_up();
  end
endmodule // serial_adc_conversion_sequencer_test
